// [common/pll_core_consts.svh]
// Constants of the core clock and power control block: offsets, fields, resets, timing.
// Assumes a 50 MHz system clock and a crystal input already synchronous to it.
//
// Overview of operation
// R1: PLL locks to crystal, delivers 4.096 MHz reference.
// R2: Divider field sets core clock to 4.096/2^n.
// R3: Divider field resets to 010, core 1.024 MHz.
// R4: Metering clock fixed at reference divided by five.
// R5: Power control write needs prior unlock key 0xA7.
// R6: Software writes key, then power control value.
// R7: Lock loss resets MCU, sets surviving fault flag.
// R8: Software acknowledges fault; device clears fault flag.
// R9: Shutdown bit halts core only in mode 1.
// R10: Serial edge wake from sleep sets wake flag.
// R11: Supply source bit, 1 for main, resets 1.
// R12: Supply health bit reads main supply adequacy.
// R13: Software sets external reference enable when connected.
// R14: Acknowledge bit 7 write clears fault flag.
// R15: Each unlock serves one write, non-key write cancels; the code cancels only on a wrong key value or a power control write.
// R16: Reserved bits read zero, ignore writes.
`ifndef PLL_CORE_CONSTS_SVH
`define PLL_CORE_CONSTS_SVH

// ----------------------------------------------------------------------------
// Clock rates and timing
// ----------------------------------------------------------------------------
`define CLK_FREQ_HZ        50000000
`define XTAL_FREQ_HZ       32768
`define REF_FREQ_HZ        4096000
`define METER_DIV          5
`define LOCK_NOM_CYC       (`CLK_FREQ_HZ / `XTAL_FREQ_HZ)
`define LOCK_TOL_CYC       16
`define LOCK_TIMEOUT_CYC   (2 * `LOCK_NOM_CYC)
`define LOCK_GOOD_PERIODS  4
`define FAULT_RST_CYC      16

// ----------------------------------------------------------------------------
// Register indices; byte address is four times the index
// ----------------------------------------------------------------------------
`define IDX_KEY            8'hC1
`define IDX_PWR            8'hC5
`define IDX_MSTART         8'hD8
`define IDX_PERIPHERAL_CONFIG_REG         8'hF4
`define IDX_IRQ_STAT       8'hE0
`define IDX_IRQ_EN         8'hE1
`define IDX_IRQ_CLR        8'hE2

// ----------------------------------------------------------------------------
// Field positions, key and reset values
// ----------------------------------------------------------------------------
`define UNLOCK_KEY         8'hA7
`define PWR_SHUTDOWN_BIT   4
`define PWR_DIV_RST        3'h2
`define PER_RX_WAKE_BIT    7
`define PER_SUPPLY_BIT     6
`define PER_VDD_OK_BIT     5
`define PER_FAULT_BIT      4
`define PER_EXTREF_BIT     2
`define SUPPLY_RST         1'h1
`define MSTART_ACK_BIT     7
`define IRQ_FAULT_BIT      0
`define IRQ_RX_BIT         1
`define IRQ_LOCK_BIT       2
`define IRQ_W              3

`endif

// [common/pll_core_pkg.sv]
// Types shared by the clock control block and its divider.
// Assumes the constants header is compiled alongside.
package pll_core_pkg;

    // Lock monitor states.
    typedef enum logic [1:0] {
        LOCK_SEARCH,
        LOCK_RUN,
        LOCK_RESET
    } lock_state_t;

    // Clock enable pulses produced from the reference.
    typedef struct packed {
        logic ref_en;
        logic core_en;
        logic meter_en;
    } clk_en_t;

    // Stored power control fields.
    typedef struct packed {
        logic       shutdown;
        logic [2:0] div;
    } power_ctrl_t;

endpackage

// [design/clock_divider_core.sv]
// Binary core clock divider and fixed metering divider on reference enables.
// Assumes ref_en is a one-cycle pulse at the reference rate.
`include "pll_core_consts.svh"

module clock_divider_core
    import pll_core_pkg::*;
#(
    parameter int DIV_W     = 3,
    parameter int METER_DIV = `METER_DIV
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             ref_en,
    input  wire logic [DIV_W-1:0] core_divider_sel,
    output clk_en_t               en_q
);

    localparam int CW = (1 << DIV_W) - 1;
    localparam int MW = $clog2(METER_DIV);

    if (DIV_W < 1 || DIV_W > 4 || METER_DIV < 2) begin : g_chk
        $error("clock_divider_core: unsupported parameters");
    end

    // Last count of a divide by two to the power sel.
    function automatic logic [CW-1:0] div_limit(input logic [DIV_W-1:0] sel);
        div_limit = CW'((1 << sel) - 1);
    endfunction

    logic [CW-1:0] core_cnt_q;
    logic [MW-1:0] meter_cnt_q;

    // Wrap points of both dividers; the metering path ignores the selector.
    wire core_wrap  = core_cnt_q >= div_limit(core_divider_sel); // R2
    wire meter_wrap = meter_cnt_q == MW'(METER_DIV - 1);         // R4

    // Counters advance on reference pulses only.
    always_ff @(posedge clk) begin
        if (rst) begin
            core_cnt_q  <= '0;
            meter_cnt_q <= '0;
            en_q        <= '0;
        end else begin
            if (ref_en) begin
                core_cnt_q  <= core_wrap ? '0 : core_cnt_q + 1'b1;
                meter_cnt_q <= meter_wrap ? '0 : meter_cnt_q + 1'b1;
            end
            en_q <= '{ref_en: ref_en, core_en: ref_en & core_wrap, meter_en: ref_en & meter_wrap};
        end
    end

    // Reference pulses counted since the last metering pulse, for checking.
    logic [3:0] ref_seen_q;
    always_ff @(posedge clk) begin
        if (rst || en_q.meter_en) begin
            ref_seen_q <= {3'h0, ref_en};
        end else if (ref_en) begin
            ref_seen_q <= ref_seen_q + 4'h1;
        end
    end

    a_core_full: assert property (@(posedge clk) disable iff (rst) // R2
        (core_divider_sel == '0 && ref_en) |=> en_q.core_en)
        else $error("core enable missing at divide by one");

    a_meter_ratio: assert property (@(posedge clk) disable iff (rst) // R4
        (en_q.meter_en && $past(en_q.meter_en, 12) == 1'b0 && ref_seen_q > 4'h0)
        |-> ref_seen_q == 4'h5 || $past(rst, 1))
        else $error("metering enable not every fifth reference pulse");

endmodule

// [design/pll_core_clock_control.sv]
// Clock and power control: crystal lock monitor, reference enable, core and
// metering dividers, key protected power control, fault and peripheral status.
// Assumes an Avalon-MM master with byte addresses and synchronous pin inputs.
//
// The Avalon-MM slave port was decided locally.
`include "pll_core_consts.svh"

module pll_core_clock_control
    import pll_core_pkg::*;
#(
    parameter int LOCK_TOL   = `LOCK_TOL_CYC,
    parameter int LOCK_GOOD  = `LOCK_GOOD_PERIODS,
    parameter int FAULT_RSTC = `FAULT_RST_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        xtal_in,
    input  wire logic        low_power_mode_1,
    input  wire logic        sleep_mode_2,
    input  wire logic        serial_rx_edge,
    input  wire logic        main_supply_sel,
    input  wire logic        vdd_ok,
    input  wire logic [9:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             irq,
    output logic             pll_locked,
    output logic             mcu_reset,
    output logic             core_halt,
    output logic             external_ref_enable,
    output logic             ref_clk_en,
    output logic             core_clk_en,
    output logic             meter_clk_en
);

    localparam int NOM_CYC = `LOCK_NOM_CYC;
    localparam int TMO_CYC = `LOCK_TIMEOUT_CYC;

    if (LOCK_TOL < 1 || LOCK_TOL >= NOM_CYC || LOCK_GOOD < 1 || LOCK_GOOD > 7
        || FAULT_RSTC < 1 || FAULT_RSTC > 31) begin : g_chk
        $error("pll_core_clock_control: unsupported parameters");
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------------------
    // Bus slave
    // ------------------------------------------------------------------------

    logic [31:0] rdata_q;
    logic        wait_q;

    // Word index of the request and its access strobes at the accepting edge.
    wire [7:0] idx      = avs_address[9:2];
    wire       wr_acc   = avs_write & ~wait_q;
    wire [7:0] wbyte    = avs_writedata[7:0];
    wire       wr_key   = wr_acc && idx == `IDX_KEY;
    wire       wr_pwr   = wr_acc && idx == `IDX_PWR;
    wire       wr_mst   = wr_acc && idx == `IDX_MSTART;
    wire       wr_per   = wr_acc && idx == `IDX_PERIPHERAL_CONFIG_REG;
    wire       wr_ien   = wr_acc && idx == `IDX_IRQ_EN;
    wire       wr_iclr  = wr_acc && idx == `IDX_IRQ_CLR;

    // Each request waits one cycle, then is answered at the next edge.
    always_ff @(posedge clk) begin
        if (rst) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= ~((avs_read | avs_write) & wait_q);
        end
    end

    // ------------------------------------------------------------------------
    // Lock monitor
    // ------------------------------------------------------------------------

    lock_state_t state_q;
    logic        xtal_q;
    logic [11:0] per_cnt_q;
    logic [2:0]  good_cnt_q;
    logic [4:0]  rst_cnt_q;

    // Period of the crystal measured in system clocks, checked against a window.
    wire xtal_rise = xtal_in & ~xtal_q;
    wire per_good  = per_cnt_q >= 12'(NOM_CYC - LOCK_TOL) && per_cnt_q <= 12'(NOM_CYC + LOCK_TOL);
    wire timeout   = per_cnt_q >= 12'(TMO_CYC);
    wire bad_per   = (xtal_rise & ~per_good) | timeout;
    wire lock_lost = state_q == LOCK_RUN && bad_per;
    wire lock_got  = state_q == LOCK_SEARCH && xtal_rise && per_good
                     && good_cnt_q == 3'(LOCK_GOOD - 1);

    // Period counter restarts on each rising crystal edge and on a timeout.
    always_ff @(posedge clk) begin
        if (rst) begin
            xtal_q    <= 1'b0;
            per_cnt_q <= '0;
        end else begin
            xtal_q    <= xtal_in;
            per_cnt_q <= (xtal_rise | timeout) ? 12'h000 : per_cnt_q + 12'h001;
        end
    end

    // Lock is declared after several good periods in a row and dropped on
    // any bad one; dropping it holds the MCU in reset for a fixed time.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q    <= LOCK_SEARCH;
            good_cnt_q <= '0;
            rst_cnt_q  <= '0;
        end else begin
            case (state_q)
                LOCK_SEARCH: begin
                    if (bad_per) begin
                        good_cnt_q <= '0;
                    end else if (lock_got) begin // R1
                        state_q <= LOCK_RUN;
                    end else if (xtal_rise) begin
                        good_cnt_q <= good_cnt_q + 3'h1;
                    end
                end
                LOCK_RUN: begin
                    if (bad_per) begin // R7
                        state_q    <= LOCK_RESET;
                        good_cnt_q <= '0;
                        rst_cnt_q  <= 5'(FAULT_RSTC - 1);
                    end
                end
                LOCK_RESET: begin
                    if (rst_cnt_q == 5'h00) begin
                        state_q <= LOCK_SEARCH;
                    end else begin
                        rst_cnt_q <= rst_cnt_q - 5'h01;
                    end
                end
                default: begin
                    state_q <= LOCK_SEARCH;
                end
            endcase
        end
    end

    // Lock and MCU reset outputs follow the monitor state.
    always_ff @(posedge clk) begin
        if (rst) begin
            pll_locked <= 1'b0;
            mcu_reset  <= 1'b0;
        end else begin
            pll_locked <= (state_q == LOCK_RUN && !bad_per) || lock_got;
            mcu_reset  <= lock_lost || (state_q == LOCK_RESET && rst_cnt_q != 5'h00); // R7
        end
    end

    // ------------------------------------------------------------------------
    // Reference enable and dividers
    // ------------------------------------------------------------------------

    logic [31:0] acc_q;
    logic        ref_pulse;

    // Fractional accumulator gives 4.096 MHz average pulses from 50 MHz.
    wire [31:0] acc_sum  = acc_q + 32'(`REF_FREQ_HZ);
    wire        acc_wrap = acc_sum >= 32'(`CLK_FREQ_HZ);

    // The reference only runs while the crystal is locked.
    always_ff @(posedge clk) begin
        if (rst || !pll_locked) begin
            acc_q     <= '0;
            ref_pulse <= 1'b0;
        end else begin
            acc_q     <= acc_wrap ? acc_sum - 32'(`CLK_FREQ_HZ) : acc_sum;
            ref_pulse <= acc_wrap; // R1
        end
    end

    power_ctrl_t pwr_q;
    clk_en_t     en;

    // Core and metering dividers; the selector never reaches the metering path.
    clock_divider_core #(
        .DIV_W     (3),
        .METER_DIV (`METER_DIV)
    ) u_div (
        .clk              (clk),
        .rst              (rst),
        .ref_en           (ref_pulse),
        .core_divider_sel (pwr_q.div), // R2
        .en_q             (en)
    );

    assign ref_clk_en   = en.ref_en;
    assign core_clk_en  = en.core_en;
    assign meter_clk_en = en.meter_en; // R4

    // ------------------------------------------------------------------------
    // Power control and unlock key
    // ------------------------------------------------------------------------

    logic unlock_q;

    // The key arms one write; the power control write or a wrong key disarms.
    always_ff @(posedge clk) begin
        if (rst || mcu_reset) begin
            unlock_q <= 1'b0;
        end else if (wr_key) begin
            unlock_q <= wbyte == `UNLOCK_KEY; // R15
        end else if (wr_pwr) begin
            unlock_q <= 1'b0; // R15
        end
    end

    // Power control takes a value only while unlocked; reserved bits drop.
    always_ff @(posedge clk) begin
        if (rst || mcu_reset) begin
            pwr_q <= '{shutdown: 1'b0, div: `PWR_DIV_RST}; // R3
        end else if (wr_pwr && unlock_q) begin // R5
            pwr_q <= '{shutdown: wbyte[`PWR_SHUTDOWN_BIT], div: wbyte[2:0]}; // R16
        end
    end

    // The core halts only while the shutdown bit meets low power mode 1.
    always_ff @(posedge clk) begin
        if (rst) begin
            core_halt <= 1'b0;
        end else begin
            core_halt <= pwr_q.shutdown & low_power_mode_1; // R9
        end
    end

    // ------------------------------------------------------------------------
    // Peripheral configuration and status
    // ------------------------------------------------------------------------

    logic fault_q;
    logic rx_wake_q;
    logic supply_q;
    logic vdd_ok_q;

    // Fault set wins over the acknowledge; MCU reset leaves the flag alone.
    wire fault_ack = wr_mst & wbyte[`MSTART_ACK_BIT];
    wire rx_event  = serial_rx_edge & sleep_mode_2;
    wire rx_clr    = wr_per & ~wbyte[`PER_RX_WAKE_BIT];

    // Sticky fault and wake flags.
    always_ff @(posedge clk) begin
        if (rst) begin
            fault_q   <= 1'b0;
            rx_wake_q <= 1'b0;
        end else begin
            fault_q   <= lock_lost | (fault_q & ~fault_ack); // R7 R8 R14
            rx_wake_q <= rx_event | (rx_wake_q & ~rx_clr);   // R10
        end
    end

    // Supply status bits sample their inputs every cycle.
    always_ff @(posedge clk) begin
        if (rst) begin
            supply_q <= `SUPPLY_RST;
            vdd_ok_q <= 1'b0;
        end else begin
            supply_q <= main_supply_sel; // R11
            vdd_ok_q <= vdd_ok;          // R12
        end
    end

    // External reference enable is a plain software bit.
    always_ff @(posedge clk) begin
        if (rst) begin
            external_ref_enable <= 1'b0;
        end else if (wr_per) begin
            external_ref_enable <= wbyte[`PER_EXTREF_BIT]; // R13
        end
    end

    // ------------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------------

    logic [`IRQ_W-1:0] irq_stat_q;
    logic [`IRQ_W-1:0] irq_en_q;

    // Events that set sticky status bits.
    wire [`IRQ_W-1:0] irq_evt = {lock_got, rx_event, lock_lost};
    wire [`IRQ_W-1:0] irq_clr = wr_iclr ? avs_writedata[`IRQ_W-1:0] : '0;

    // A set in the same cycle as its clear wins.
    always_ff @(posedge clk) begin
        if (rst) begin
            irq_stat_q <= '0;
            irq_en_q   <= '0;
            irq        <= 1'b0;
        end else begin
            irq_stat_q <= irq_evt | (irq_stat_q & ~irq_clr);
            if (wr_ien) begin
                irq_en_q <= avs_writedata[`IRQ_W-1:0];
            end
            irq <= |(irq_stat_q & irq_en_q);
        end
    end

    // ------------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------------

    // Peripheral register image; bits 3, 1 and 0 read zero.
    wire [7:0] per_img = {rx_wake_q, supply_q, vdd_ok_q, fault_q,
                          1'b0, external_ref_enable, 2'b00}; // R16
    wire [7:0] pwr_img = {3'b000, pwr_q.shutdown, 1'b0, pwr_q.div}; // R16
    wire [7:0] rd_byte = idx == `IDX_PWR      ? pwr_img :
                         idx == `IDX_PERIPHERAL_CONFIG_REG   ? per_img :
                         idx == `IDX_IRQ_STAT ? {5'h00, irq_stat_q} :
                         idx == `IDX_IRQ_EN   ? {5'h00, irq_en_q} : 8'h00;

    // Read data is loaded while the request waits, standing at the answer.
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_q <= '0;
        end else if (avs_read && wait_q) begin
            rdata_q <= {24'h000000, rd_byte};
        end
    end

    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------

    a_ref_gated: assert property ( // R1
        ref_pulse |-> $past(pll_locked))
        else $error("reference pulse without lock");

    a_ref_spacing: assert property ( // R1
        ref_pulse |=> !ref_pulse [*8])
        else $error("reference pulses too close");

    a_div_reset: assert property (@(posedge clk) // R3
        $past(rst) |-> pwr_q.div == `PWR_DIV_RST && !pwr_q.shutdown)
        else $error("divider field not 010 after reset");

    a_locked_write: assert property ( // R5
        (wr_pwr && !unlock_q && !mcu_reset) |=> $stable(pwr_q))
        else $error("power control changed without key");

    a_key_consumed: assert property ( // R15
        wr_pwr |=> !unlock_q)
        else $error("unlock survived a power control write");

    a_fault_sets: assert property ( // R7
        lock_lost |=> fault_q && mcu_reset ##1 mcu_reset [*2])
        else $error("lock loss did not reset or flag");

    a_fault_ack: assert property ( // R8
        (fault_ack && !lock_lost) |=> !fault_q)
        else $error("acknowledge did not clear fault flag");

    a_halt_mode: assert property ( // R9
        !low_power_mode_1 |=> !core_halt)
        else $error("core halted outside mode 1");

    a_rx_wake: assert property ( // R10
        rx_event |=> rx_wake_q ##1 per_img[7])
        else $error("serial wake flag not set");

    a_supply_reset: assert property (@(posedge clk) // R11
        $past(rst) |-> supply_q && !vdd_ok_q)
        else $error("supply bits wrong after reset");

    a_vdd_track: assert property ( // R12
        vdd_ok_q == $past(vdd_ok) || $past(rst))
        else $error("supply health bit not tracking");

    a_rsvd_zero: assert property ( // R16
        avs_readdata[31:8] == 24'h000000 && !(idx == `IDX_PERIPHERAL_CONFIG_REG && rd_byte[3]))
        else $error("reserved bits read nonzero");

endmodule

// [sim/xtal_model.sv]
// Behavioural 32.768 kHz watch crystal feeding the lock monitor.
// Assumes the 50 MHz bench clock; run low stops it and it rests low.
module xtal_model #(
    parameter int HALF = 762
) (
    input  wire logic clk,
    input  wire logic run,
    output logic      xtal_in
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt_q;
    // Halves of 762 and 763 cycles give a 1525 cycle period.
    always @(posedge clk) begin
        if (!run) begin
            xtal_in <= 1'b0;
            cnt_q <= 0;
        end else if (cnt_q >= HALF - (xtal_in ? 1 : 0)) begin
            xtal_in <= !xtal_in;
            cnt_q <= 0;
        end else begin
            cnt_q <= cnt_q + 1;
        end
    end
endmodule

// [sim/pll_core_clock_control_tb.sv]
// Self-checking bench of the clock and power control block.
// Assumes the crystal model beside it and Avalon byte addresses.
module pll_core_clock_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pll_core_pkg::*;
    logic clk = 0, rst = 1, run = 0, lpm1 = 0, slp2 = 0, rx_edge = 0, msel = 1, vok = 0;
    logic [9:0] addr = '0;
    logic rd = 0, wr = 0;
    logic [31:0] wdata = '0, rdata;
    logic wait_r, irq, locked, mrst, halt, extref, xtal, ref_en, core_en, meter_en;
    logic [7:0] q;
    int errors = 0, tests_run = 0, cycles = 0, r, c, m;
    always #10 clk = !clk;
    xtal_model xtal_model_i (.clk(clk), .run(run), .xtal_in(xtal));
    pll_core_clock_control pll_core_clock_control_i (.clk(clk), .rst(rst), .xtal_in(xtal),
        .low_power_mode_1(lpm1), .sleep_mode_2(slp2), .serial_rx_edge(rx_edge),
        .main_supply_sel(msel), .vdd_ok(vok), .avs_address(addr), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wdata), .avs_readdata(rdata),
        .avs_waitrequest(wait_r), .irq(irq), .pll_locked(locked), .mcu_reset(mrst),
        .core_halt(halt), .external_ref_enable(extref), .ref_clk_en(ref_en),
        .core_clk_en(core_en), .meter_clk_en(meter_en));
    // ------------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------------
    // One Avalon access; an edge passes after release before the next one.
    task bus(input logic w, input logic [9:0] a, input logic [7:0] d);
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= {24'h0, d};
        do @(posedge clk); while (wait_r !== 1'b0);
        q = rdata[7:0];
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
    endtask
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %0h got %0h", n, e, g);
        end
    endtask
    // Pulse counts may slip by one at a window edge.
    task chk_n(input string n, input int e, input int g);
        tests_run++;
        if (g < e - 1 || g > e + 1) begin
            errors++;
            $display("CHECK FAILED %s expected %0d got %0d", n, e, g);
        end
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    // Reset values, key protection, reserved bits, halt and status bits.
    task t_regs;
        bus(0, 10'h314, 8'h00);
        chk("power reset", 8'h02, q);
        bus(0, 10'h3D0, 8'h00);
        chk("peripheral_config_reg reset", 8'h40, q);
        bus(1, 10'h314, 8'h13);
        bus(0, 10'h314, 8'h00);
        chk("no key", 8'h02, q);
        bus(1, 10'h304, 8'hA7);
        bus(1, 10'h304, 8'h55);
        bus(1, 10'h314, 8'h13);
        bus(0, 10'h314, 8'h00);
        chk("key cancel", 8'h02, q);
        bus(1, 10'h304, 8'hA7);
        bus(1, 10'h314, 8'hFF);
        bus(0, 10'h314, 8'h00);
        chk("power reserved", 8'h17, q);
        bus(1, 10'h314, 8'h02);
        bus(0, 10'h314, 8'h00);
        chk("key used", 8'h17, q);
        repeat (2) @(posedge clk);
        chk("halt mode0", 8'h00, halt);
        lpm1 <= 1'b1;
        repeat (2) @(posedge clk);
        chk("halt mode1", 8'h01, halt);
        lpm1 <= 1'b0;
        vok <= 1'b1;
        msel <= 1'b0;
        bus(1, 10'h3D0, 8'h7F);
        bus(0, 10'h3D0, 8'h00);
        chk("peripheral_config_reg", 8'h24, q);
        chk("ext ref", 8'h01, extref);
        bus(0, 10'h000, 8'h00);
        chk("unmapped", 8'h00, q);
        $display("test regs done");
    endtask
    // Lock, then pulse rates for every divider setting.
    task t_div;
        run <= 1'b1;
        while (locked !== 1'b1) @(posedge clk);
        for (int d = 0; d < 8; d++) begin
            bus(1, 10'h304, 8'hA7);
            bus(1, 10'h314, 8'(d));
            r = 0; c = 0; m = 0;
            repeat (3125) begin
                @(posedge clk);
                r += int'(ref_en === 1'b1);
                c += int'(core_en === 1'b1);
                m += int'(meter_en === 1'b1);
            end
            chk_n("ref pulses", 256, r);
            chk_n("core pulses", 256 >> d, c);
            chk_n("meter pulses", 256 / 5, m);
        end
        $display("test div done");
    endtask
    // Lock loss, surviving fault flag, interrupt and acknowledge.
    task t_fault;
        run <= 1'b0;
        r = 0;
        while (mrst !== 1'b1 && r < 3200) begin
            @(posedge clk);
            r++;
        end
        chk("reset on loss", 8'h01, mrst);
        chk("unlocked", 8'h00, locked);
        while (mrst !== 1'b0) @(posedge clk);
        bus(0, 10'h3D0, 8'h00);
        chk("fault flag", 8'h34, q);
        bus(0, 10'h314, 8'h00);
        chk("power reinit", 8'h02, q);
        bus(0, 10'h380, 8'h00);
        chk("irq status", 8'h05, q);
        bus(1, 10'h384, 8'h01);
        @(posedge clk);
        chk("irq on", 8'h01, irq);
        bus(1, 10'h384, 8'h00);
        @(posedge clk);
        chk("irq masked", 8'h00, irq);
        bus(1, 10'h388, 8'h07);
        bus(0, 10'h380, 8'h00);
        chk("irq clear", 8'h00, q);
        bus(1, 10'h360, 8'h80);
        bus(0, 10'h3D0, 8'h00);
        chk("fault ack", 8'h24, q);
        $display("test fault done");
    endtask
    // Receive edge wake from sleep mode 2 sets the wake flag.
    task t_rx;
        slp2 <= 1'b1;
        rx_edge <= 1'b1;
        @(posedge clk);
        rx_edge <= 1'b0;
        slp2 <= 1'b0;
        bus(0, 10'h3D0, 8'h00);
        chk("rx wake", 8'hA4, q);
        bus(1, 10'h3D0, 8'h04);
        bus(0, 10'h3D0, 8'h00);
        chk("rx clear", 8'h24, q);
        $display("test rx done");
    endtask
    // Watchdog on the whole run.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 80000) begin
            errors++;
            final_report();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_div();
        t_fault();
        t_rx();
        final_report();
    end
endmodule
